/* File: common/fbbse_pkg.sv */
// shared constants and types for the flag/branch/bit/shift executor
// assumes one core clock and an apb master holding requests until pready
package fbbse_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_FLAGS  = 8'h04;
  localparam logic [7:0] ADDR_PC     = 8'h08;
  localparam logic [7:0] ADDR_WSEL   = 8'h0c;
  localparam logic [7:0] ADDR_WDATA  = 8'h10;
  localparam logic [7:0] ADDR_IOSEL  = 8'h14;
  localparam logic [7:0] ADDR_IODATA = 8'h18;

  // status flag bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // reset values
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  MEM_RST   = 8'h00;
  localparam logic [4:0]  SEL_RST   = 5'h00;

  localparam int CMD_W = 26;

  typedef enum logic [5:0] {
    op_nop,
    op_branch_on_negative, op_branch_on_positive,
    op_branch_signed_ge, op_branch_signed_lt,
    op_branch_halfcarry_one, op_branch_halfcarry_zero,
    op_branch_transfer_one, op_branch_transfer_zero,
    op_branch_overflow_one, op_branch_overflow_zero,
    op_branch_irq_on, op_branch_irq_off,
    op_io_bit_raise, op_io_bit_lower,
    op_shift_left_logical, op_shift_right_logical,
    op_rotate_left_carry, op_rotate_right_carry, op_shift_right_signed,
    op_bit_to_transfer, op_transfer_to_bit,
    op_flag_force_one, op_flag_force_zero,
    op_set_carry_op, op_clear_carry_op,
    op_set_negative_op, op_clear_negative_op,
    op_set_zero_op, op_clear_zero_op,
    op_irq_global_on, op_irq_global_off,
    op_set_sign_op, op_clear_sign_op,
    op_set_overflow_op, op_clear_overflow_op,
    op_set_transfer_op, op_clear_transfer_op,
    op_set_halfcarry_op, op_clear_halfcarry_op
  } fbbse_op_type;

  typedef enum {st_idle, st_exec, st_exec2} fbbse_state_type;

  // command word, op in the low bits
  typedef struct packed {
    logic [6:0]   offset;
    logic [4:0]   io_idx;
    logic [2:0]   bit_idx;
    logic [4:0]   reg_idx;
    fbbse_op_type op;
  } fbbse_cmd_type;

  typedef struct packed {
    logic i;
    logic t;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } fbbse_flags_type;

endpackage

/* File: dv/fbbse_host.sv */
// apb master model standing in for the core side of the executor
// assumes one core clock; requests are launched and released only right after a rising edge
`timescale 1ns/1ps
module fbbse_host (
  input  wire  logic        core_clk, // core clock
  output logic              psel,     // apb select
  output logic              penable,  // apb enable
  output logic              pwrite,   // apb direction, high writes
  output logic       [7:0]  paddr,    // apb byte address
  output logic       [31:0] pwdata,   // apb write data
  input  wire  logic [31:0] prdata,   // apb read data
  input  wire  logic        pready,   // apb ready
  input  wire  logic        pslverr   // apb error
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // one transfer; waits for pready without assuming a latency
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines show a changed value, not the last one
    paddr   <= ~a;
    pwdata  <= ~wd;
  endtask
endmodule

/* File: dv/tb.sv */
// self-checking bench for the flag/branch/bit/shift executor
// assumes fbbse_host drives the apb side; assertions live in the design files
`timescale 1ns/1ps
module tb;
  import fbbse_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  flags_out;
  logic [15:0] pc_out;
  int          fails;
  int          cmp_count;

  fbbse_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  fbbse_exec #(.PC_W(16)) dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flags_out(flags_out), .pc_out(pc_out));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    host.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        err;
    host.xfer(1'b0, a, 32'h0, d, err);
    chk(d, exp);
  endtask

  // command on working reg 3 and io reg 31
  task automatic run(input fbbse_op_type op, input logic [2:0] b, input logic [6:0] k);
    fbbse_cmd_type c;
    c = '0;
    c.op = op;
    c.reg_idx = 5'h03;
    c.bit_idx = b;
    c.io_idx = 5'h1f;
    c.offset = k;
    wr(ADDR_CMD, {6'h00, c});
  endtask

  function automatic logic taken(input int o, input fbbse_flags_type f);
    case (o)
      1: return f.n;
      2: return !f.n;
      3: return !(f.n ^ f.v);
      4: return f.n ^ f.v;
      5: return f.h;
      6: return !f.h;
      7: return f.t;
      8: return !f.t;
      9: return f.v;
      10: return !f.v;
      11: return f.i;
      default: return !f.i;
    endcase
  endfunction

  task automatic t_reset();
    logic [31:0] d;
    logic        err;
    rdc(ADDR_FLAGS, 32'(FLAGS_RST));
    chk(32'(flags_out), 32'(FLAGS_RST));
    rdc(ADDR_PC, 32'(PC_RST));
    rdc(ADDR_IODATA, 32'(MEM_RST));
    host.xfer(1'b1, 8'h40, 32'hffff_ffff, d, err);
    chk({31'h0, err}, 32'h1);
    host.xfer(1'b0, 8'h40, 32'h0, d, err);
    chk({31'h0, err}, 32'h1);
    chk(d, 32'h0);
  endtask

  // backward offset -3 from 0x0100 lands on 0x00fe
  task automatic t_branch();
    logic [7:0] fl [3];
    logic       tk;
    fl = '{8'h00, 8'hff, 8'h04};
    for (int o = 1; o <= 12; o++) begin
      for (int j = 0; j < 3; j++) begin
        wr(ADDR_FLAGS, 32'(fl[j]));
        wr(ADDR_PC, 32'h0000_0100);
        run(fbbse_op_type'(o), 3'h0, 7'h7d);
        tk = taken(o, fl[j]);
        @(posedge core_clk);
        #1;
        chk(32'(pc_out), tk ? 32'h0100 : 32'h0101);
        @(posedge core_clk);
        #1;
        chk(32'(pc_out), tk ? 32'h00fe : 32'h0101);
        rdc(ADDR_FLAGS, 32'(fl[j]));
      end
    end
  endtask

  task automatic t_io();
    wr(ADDR_IOSEL, 32'h1f);
    wr(ADDR_IODATA, 32'h5a);
    wr(ADDR_FLAGS, 32'ha5);
    run(op_io_bit_raise, 3'h7, 7'h00);
    rdc(ADDR_IODATA, 32'hda);
    run(op_io_bit_lower, 3'h1, 7'h00);
    rdc(ADDR_IODATA, 32'hd8);
    rdc(ADDR_FLAGS, 32'ha5);
    wr(ADDR_IOSEL, 32'h00);
    rdc(ADDR_IODATA, 32'h00);
  endtask

  task automatic t_shift();
    logic [7:0] a [3];
    logic [7:0] x;
    logic [7:0] r;
    logic       co;
    logic       ci;
    a = '{8'h81, 8'h01, 8'h40};
    wr(ADDR_WSEL, 32'h03);
    for (int o = 15; o <= 19; o++) begin
      for (int j = 0; j < 6; j++) begin
        ci = j[0];
        x = a[j/2];
        case (o)
          15: r = {x[6:0], 1'b0};
          16: r = {1'b0, x[7:1]};
          17: r = {x[6:0], ci};
          18: r = {ci, x[7:1]};
          default: r = {x[7], x[7:1]};
        endcase
        co = (o == 15 || o == 17) ? x[7] : x[0];
        wr(ADDR_FLAGS, {24'h0, 7'h78, ci});
        wr(ADDR_WDATA, 32'(x));
        run(fbbse_op_type'(o), 3'h0, 7'h00);
        rdc(ADDR_WDATA, 32'(r));
        rdc(ADDR_FLAGS, {24'h0, 4'hf, r[7] ^ co, r[7], r == 8'h00, co});
      end
    end
  endtask

  task automatic t_bits();
    wr(ADDR_WSEL, 32'h03);
    wr(ADDR_FLAGS, 32'h00);
    wr(ADDR_WDATA, 32'h20);
    run(op_bit_to_transfer, 3'h5, 7'h00);
    rdc(ADDR_FLAGS, 32'h40);
    wr(ADDR_FLAGS, 32'hff);
    run(op_bit_to_transfer, 3'h4, 7'h00);
    rdc(ADDR_FLAGS, 32'hbf);
    wr(ADDR_FLAGS, 32'h40);
    wr(ADDR_WDATA, 32'h00);
    run(op_transfer_to_bit, 3'h7, 7'h00);
    rdc(ADDR_WDATA, 32'h80);
    rdc(ADDR_FLAGS, 32'h40);
    wr(ADDR_FLAGS, 32'hbf);
    wr(ADDR_WDATA, 32'hff);
    run(op_transfer_to_bit, 3'h0, 7'h00);
    rdc(ADDR_WDATA, 32'hfe);
  endtask

  // generic forms first, then the dedicated set/clear pairs in code order
  task automatic t_flags();
    logic [2:0]   pos [8];
    logic [2:0]   b;
    logic [7:0]   e;
    logic         v;
    fbbse_op_type o;
    pos = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T, FLAG_H};
    for (int k = 0; k < 32; k++) begin
      v = !k[0];
      b = (k < 16) ? 3'(k / 2) : pos[(k - 16) / 2];
      if (k < 16) begin
        o = v ? op_flag_force_one : op_flag_force_zero;
      end else begin
        o = fbbse_op_type'(k + 8);
      end
      e = v ? 8'h00 : 8'hff;
      wr(ADDR_FLAGS, 32'(e));
      e[b] = v;
      run(o, b, 7'h00);
      rdc(ADDR_FLAGS, 32'(e));
      chk(32'(flags_out), 32'(e));
    end
  endtask

  initial begin
    #100000;
    fails++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    fails = 0;
    cmp_count = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_branch();
    t_io();
    t_shift();
    t_bits();
    t_flags();
    finish_test();
  end
endmodule

/* File: logic/fbbse_exec.sv */
// executor for flag branches, io bit set/clear, shifts, bit transfer and flag ops
// assumes an apb master on core_clk; commands are issued by writing the command word
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module fbbse_exec
  import fbbse_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire  logic            core_clk,  // core clock, 200 MHz
  input  wire  logic            rst,       // async reset, active high
  input  wire  logic            psel,      // apb select
  input  wire  logic            penable,   // apb enable
  input  wire  logic            pwrite,    // apb write
  input  wire  logic [7:0]      paddr,     // apb byte address
  input  wire  logic [31:0]     pwdata,    // apb write data
  output logic       [31:0]     prdata,    // apb read data
  output logic                  pready,    // apb ready
  output logic                  pslverr,   // apb error on unmapped address
  output logic       [7:0]      flags_out, // status flags
  output logic       [PC_W-1:0] pc_out     // program counter
);

  fbbse_state_type state_reg;
  fbbse_cmd_type   cmd_reg;
  logic [7:0]      flags_reg;
  logic [PC_W-1:0] pc_reg;
  logic [4:0]      wsel_reg;
  logic [4:0]      iosel_reg;
  logic [7:0]      wreg_mem [32];
  logic [7:0]      io_mem [32];
  logic            pready_reg;
  logic            pslverr_reg;
  logic [31:0]     prdata_reg;

  fbbse_flags_type fv;
  logic            acc_req;
  logic            wr_done;
  logic [31:0]     rd_value;
  logic [7:0]      operand;
  logic [7:0]      sh_res;
  logic            sh_c;
  logic            br_taken;
  logic [PC_W-1:0] br_target;
  logic [PC_W-1:0] pc_inc;
  logic            in_exec;
  logic [4:0]      fop;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ADDR_CMD) || (a == ADDR_FLAGS) || (a == ADDR_PC) ||
                  (a == ADDR_WSEL) || (a == ADDR_WDATA) || (a == ADDR_IOSEL) ||
                  (a == ADDR_IODATA);
  endfunction

  function automatic logic is_branch(input fbbse_op_type op);
    is_branch = (op >= op_branch_on_negative) && (op <= op_branch_irq_off);
  endfunction

  function automatic logic is_shift(input fbbse_op_type op);
    is_shift = (op >= op_shift_left_logical) && (op <= op_shift_right_signed);
  endfunction

  function automatic logic is_io(input fbbse_op_type op);
    is_io = (op == op_io_bit_raise) || (op == op_io_bit_lower);
  endfunction

  function automatic logic branch_cond(input fbbse_op_type op, input fbbse_flags_type f);
    case (op)
      op_branch_on_negative:    branch_cond = f.n;
      op_branch_on_positive:    branch_cond = !f.n;
      op_branch_signed_ge:      branch_cond = (f.n ^ f.v) == 1'b0;
      op_branch_signed_lt:      branch_cond = (f.n ^ f.v) == 1'b1;
      op_branch_halfcarry_one:  branch_cond = f.h;
      op_branch_halfcarry_zero: branch_cond = !f.h;
      op_branch_transfer_one:   branch_cond = f.t;
      op_branch_transfer_zero:  branch_cond = !f.t;
      op_branch_overflow_one:   branch_cond = f.v;
      op_branch_overflow_zero:  branch_cond = !f.v;
      op_branch_irq_on:         branch_cond = f.i;
      op_branch_irq_off:        branch_cond = !f.i;
      default:                  branch_cond = 1'b0;
    endcase
  endfunction

  // returns {force, value, index}; indexed forms take bit_idx
  function automatic logic [4:0] flag_op(input fbbse_op_type op, input logic [2:0] s);
    case (op)
      op_flag_force_one:    flag_op = {2'b11, s};
      op_flag_force_zero:   flag_op = {2'b10, s};
      op_set_carry_op:      flag_op = {2'b11, FLAG_C};
      op_clear_carry_op:    flag_op = {2'b10, FLAG_C};
      op_set_negative_op:   flag_op = {2'b11, FLAG_N};
      op_clear_negative_op: flag_op = {2'b10, FLAG_N};
      op_set_zero_op:       flag_op = {2'b11, FLAG_Z};
      op_clear_zero_op:     flag_op = {2'b10, FLAG_Z};
      op_irq_global_on:     flag_op = {2'b11, FLAG_I};
      op_irq_global_off:    flag_op = {2'b10, FLAG_I};
      op_set_sign_op:       flag_op = {2'b11, FLAG_S};
      op_clear_sign_op:     flag_op = {2'b10, FLAG_S};
      op_set_overflow_op:   flag_op = {2'b11, FLAG_V};
      op_clear_overflow_op: flag_op = {2'b10, FLAG_V};
      op_set_transfer_op:   flag_op = {2'b11, FLAG_T};
      op_clear_transfer_op: flag_op = {2'b10, FLAG_T};
      op_set_halfcarry_op:  flag_op = {2'b11, FLAG_H};
      op_clear_halfcarry_op: flag_op = {2'b10, FLAG_H};
      default:              flag_op = 5'h00;
    endcase
  endfunction

  assign fv        = fbbse_flags_type'(flags_reg);
  // registers are touched only while idle, so exec and bus never collide
  assign acc_req   = psel && penable && !pready_reg && (state_reg == st_idle);
  assign wr_done   = psel && penable && pready_reg && pwrite;
  assign in_exec   = (state_reg == st_exec);
  assign operand   = wreg_mem[cmd_reg.reg_idx];
  assign br_taken  = branch_cond(cmd_reg.op, fv);
  assign fop       = flag_op(cmd_reg.op, cmd_reg.bit_idx);
  assign pc_inc    = pc_reg + PC_W'(1);
  assign br_target = pc_reg + PC_W'($signed(cmd_reg.offset)) + PC_W'(1);

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign flags_out = flags_reg;
  assign pc_out    = pc_reg;

  fbbse_shift u_shift (
    .op        (cmd_reg.op),
    .operand   (operand),
    .carry_in  (fv.c),
    .result    (sh_res),
    .carry_out (sh_c)
  );

  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr)
      ADDR_CMD:    rd_value = {{(32-CMD_W){1'b0}}, cmd_reg};
      ADDR_FLAGS:  rd_value = {24'h00_0000, flags_reg};
      ADDR_PC:     rd_value = 32'(pc_reg);
      ADDR_WSEL:   rd_value = {27'h000_0000, wsel_reg};
      ADDR_WDATA:  rd_value = {24'h00_0000, wreg_mem[wsel_reg]};
      ADDR_IOSEL:  rd_value = {27'h000_0000, iosel_reg};
      ADDR_IODATA: rd_value = {24'h00_0000, io_mem[iosel_reg]};
      default:     rd_value = 32'h0000_0000;
    endcase
  end

  // apb answer: ready one cycle, data and error with it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (acc_req) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !addr_mapped(paddr);
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_value;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wsel_reg  <= SEL_RST;
      iosel_reg <= SEL_RST;
    end else if (wr_done && paddr == ADDR_WSEL) begin
      wsel_reg  <= pwdata[4:0];
    end else if (wr_done && paddr == ADDR_IOSEL) begin
      iosel_reg <= pwdata[4:0];
    end
  end

  // sequencing: one-cycle ops leave after st_exec
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= st_idle;
      cmd_reg   <= fbbse_cmd_type'(0);
    end else begin
      case (state_reg)
        st_idle: begin
          if (wr_done && paddr == ADDR_CMD) begin
            cmd_reg   <= fbbse_cmd_type'(pwdata[CMD_W-1:0]);
            state_reg <= st_exec;
          end
        end
        st_exec: begin
          if ((is_branch(cmd_reg.op) && br_taken) || is_io(cmd_reg.op)) begin
            state_reg <= st_exec2;
          end else begin
            state_reg <= st_idle;
          end
        end
        st_exec2: state_reg <= st_idle;
        default:  state_reg <= st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pc_reg <= PC_RST[PC_W-1:0];
    end else if (wr_done && paddr == ADDR_PC) begin
      pc_reg <= pwdata[PC_W-1:0];
    end else if (in_exec) begin
      if (!((is_branch(cmd_reg.op) && br_taken) || is_io(cmd_reg.op))) begin
        pc_reg <= pc_inc;
      end
    end else if (state_reg == st_exec2) begin
      pc_reg <= is_branch(cmd_reg.op) ? br_target : pc_inc;
    end
  end

  // branches and io ops leave the flags alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= FLAGS_RST;
    end else if (wr_done && paddr == ADDR_FLAGS) begin
      flags_reg <= pwdata[7:0];
    end else if (in_exec) begin
      if (is_shift(cmd_reg.op)) begin
        flags_reg[FLAG_Z] <= (sh_res == 8'h00);
        flags_reg[FLAG_C] <= sh_c;
        flags_reg[FLAG_N] <= sh_res[7];
        flags_reg[FLAG_V] <= sh_res[7] ^ sh_c;
      end else if (cmd_reg.op == op_bit_to_transfer) begin
        flags_reg[FLAG_T] <= operand[cmd_reg.bit_idx];
      end else if (fop[4]) begin
        flags_reg[fop[2:0]] <=
          fop[3];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 32; k++) wreg_mem[k] <= MEM_RST;
    end else if (wr_done && paddr == ADDR_WDATA) begin
      wreg_mem[wsel_reg] <= pwdata[7:0];
    end else if (in_exec && is_shift(cmd_reg.op)) begin
      wreg_mem[cmd_reg.reg_idx] <= sh_res;
    end else if (in_exec && cmd_reg.op == op_transfer_to_bit) begin
      wreg_mem[cmd_reg.reg_idx][cmd_reg.bit_idx] <= fv.t;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 32; k++) io_mem[k] <= MEM_RST;
    end else if (wr_done && paddr == ADDR_IODATA) begin
      io_mem[iosel_reg] <= pwdata[7:0];
    end else if (state_reg == st_exec2 && is_io(cmd_reg.op)) begin
      // io bit written on second cycle
      io_mem[cmd_reg.io_idx][cmd_reg.bit_idx] <= (cmd_reg.op == op_io_bit_raise);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_branch_target_pc: assert property (
    in_exec && is_branch(cmd_reg.op) && br_taken |-> ##2 pc_reg == $past(br_target, 2)
  ) else $error("taken branch did not land on target");

  a_signed_ge_take: assert property (
    in_exec && cmd_reg.op == op_branch_signed_ge |=>
      (state_reg == st_exec2) == ($past(fv.n ^ fv.v) == 1'b0)
  ) else $error("signed ge branch decision wrong");

  a_signed_lt_take: assert property (
    in_exec && cmd_reg.op == op_branch_signed_lt && (fv.n ^ fv.v) |=> state_reg == st_exec2
  ) else $error("signed lt branch not taken");

  a_halfcarry_skip: assert property (
    in_exec && cmd_reg.op == op_branch_halfcarry_one && !fv.h |=>
      state_reg == st_idle && pc_reg == $past(pc_inc)
  ) else $error("half carry branch taken on clear flag");

  a_transfer_take: assert property (
    in_exec && cmd_reg.op == op_branch_transfer_zero && !fv.t |=> state_reg == st_exec2
  ) else $error("transfer clear branch not taken");

  a_irq_branch_take: assert property (
    in_exec && cmd_reg.op == op_branch_irq_on |=> (state_reg == st_exec2) == $past(fv.i)
  ) else $error("interrupt branch decision wrong");

  a_io_raise_bit: assert property (
    in_exec && cmd_reg.op == op_io_bit_raise |=> state_reg == st_exec2 ##1
      io_mem[cmd_reg.io_idx][cmd_reg.bit_idx] && $stable(flags_reg)
  ) else $error("io bit raise failed");

  a_io_lower_bit: assert property (
    in_exec && cmd_reg.op == op_io_bit_lower |-> ##2 !io_mem[cmd_reg.io_idx][cmd_reg.bit_idx]
  ) else $error("io bit lower failed");

  a_shl_result: assert property (
    in_exec && cmd_reg.op == op_shift_left_logical |=>
      wreg_mem[cmd_reg.reg_idx] == {$past(operand[6:0]), 1'b0} && fv.c == $past(operand[7])
  ) else $error("left shift result wrong");

  a_rol_carry: assert property (
    in_exec && cmd_reg.op == op_rotate_left_carry |=>
      wreg_mem[cmd_reg.reg_idx][0] == $past(fv.c) && fv.c == $past(operand[7])
  ) else $error("rotate left carry wrong");

  a_bit_store_t: assert property (
    in_exec && cmd_reg.op == op_bit_to_transfer |=>
      fv.t == $past(operand[cmd_reg.bit_idx]) && flags_reg[5:0] == $past(flags_reg[5:0])
  ) else $error("bit store to transfer wrong");

  a_flag_force_one: assert property (
    in_exec && cmd_reg.op == op_flag_force_one |=> flags_reg[cmd_reg.bit_idx] && state_reg == st_idle
  ) else $error("indexed flag set failed");

  a_irq_off_flag: assert property (
    in_exec && cmd_reg.op == op_irq_global_off |=> !fv.i
  ) else $error("interrupt disable failed");

  a_untaken_one_cycle: assert property (
    in_exec && is_branch(cmd_reg.op) && !br_taken |=> state_reg == st_idle && $stable(flags_reg)
  ) else $error("untaken branch not single cycle");

  a_asr_sign_keep: assert property (
    in_exec && cmd_reg.op == op_shift_right_signed |=>
      wreg_mem[cmd_reg.reg_idx][7] == $past(operand[7]) && fv.c == $past(operand[0])
  ) else $error("signed shift lost sign");

endmodule

/* File: logic/fbbse_shift.sv */
// shift and rotate datapath for one working register byte
// assumes the caller only looks at the result for shift/rotate ops
`timescale 1ns/1ps
module fbbse_shift
  import fbbse_pkg::*;
(
  input  fbbse_op_type op,        // operation being executed
  input  wire  logic [7:0] operand, // old register value
  input  wire  logic       carry_in, // old carry flag
  output logic [7:0]       result,  // new register value
  output logic             carry_out // new carry flag
);

  always_comb begin
    result    = operand;
    carry_out = carry_in;
    case (op)
      op_shift_left_logical: begin
        result    = {operand[6:0], 1'b0};
        carry_out = operand[7];
      end
      op_shift_right_logical: begin
        result    = {1'b0, operand[7:1]};
        carry_out = operand[0];
      end
      op_rotate_left_carry: begin
        result    = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      op_rotate_right_carry: begin
        result    = {carry_in, operand[7:1]};
        carry_out = operand[0];
      end
      // sign bit stays in place
      op_shift_right_signed: begin
        result    = {operand[7], operand[7:1]};
        carry_out = operand[0];
      end
      default: begin
        result    = operand;
        carry_out = carry_in;
      end
    endcase
  end

endmodule
